//--- verilog/rul_top.sv
// Top of the unlock, access-window and time-of-day block.
// Assumes a register master that holds strobes one cycle and never waits.
//
// Summary of operation
// - Exact 31-bit key releases clock from reset.
// - Once released, the clock stays released.
// - Key field always reads as zero.
// - Bit 0 shows running status.
// - Password write opens access; write only.
// - Open flag set on load, clears after 1024.
// - Clock registers accessible only while flag set.
// - Compensation read back only while flag set.
// - Hour digits at bits 21:16.
// - Minute and second digits below hour.
// - Bit 21 marks PM in 12-hour scale.
// - Loaded time digits are not checked.
// - Scale select: 0 twelve-hour, 1 full day.
//
// Design decision made here: the strobed register port.
`default_nettype none
module rul_top #(
  parameter int SEC_COUNT = rul_pkg::SEC_CYCLES  // Cycles per second tick.
) (
  input  wire logic            core_clk_i,  // Core clock, 20 MHz.
  input  wire logic            rst_n_i,     // Async reset, active low.
  input  wire rul_pkg::rul_req_t req_i,     // Register request.
  output logic [31:0]          rdata_o,     // Read data, cycle after read.
  output logic                 running_o    // Clock out of reset.
);
  import rul_pkg::*;
  // ----------------------------------------------------------------------
  // Hazards
  // ----------------------------------------------------------------------
  // The release latch has no software clear: only the reset pin can put
  // the clock back into its held state, so a stray key write is harmless.
  // The access window gates both reads and writes of the clock registers.
  // A read that lands after the window has closed returns zero, and the
  // write that lands then is dropped without any error indication, so
  // software must reload the password before every burst of accesses.
  // The window runs on the core clock; with a slower link clock the span
  // in time would differ, which is why its length is a parameter below.
  // The time digits neither advance nor load while held, so a held clock
  // keeps its reset value until the key arrives.
  // Time-scale changes take effect at the next carry into the hour digits;
  // digits already loaded are not converted between the two scales.
  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic        run_reg;        // Released from reset.
  logic        open;           // Access window open.
  logic [31:0] freq_reg;       // Compensation value.
  logic        scale_reg;      // Full-day scale select.
  logic [31:0] time_val;       // Current time.
  logic [31:0] rdata_reg;      // Read data holding register.
  logic [$clog2(SEC_COUNT)-1:0] sec_cnt_reg; // Second prescaler.
  wire  sel_unlock = req_i.addr == OFS_UNLOCK; // Unlock register hit.
  wire  sel_access = req_i.addr == OFS_ACCESS; // Access register hit.
  wire  sel_freq   = req_i.addr == OFS_FREQ;   // Compensation hit.
  wire  sel_time   = req_i.addr == OFS_TIME;   // Time hit.
  wire  sel_scale  = req_i.addr == OFS_SCALE;  // Scale hit.
  wire  key_ok     = req_i.wr && sel_unlock && req_i.wdata[31:1] == UNLOCK_KEY;
  wire  pwd_ok     = req_i.wr && sel_access && req_i.wdata[15:0] == ACCESS_PWD;
  // Clock register writes only land while released and the window is open.
  wire  wr_ok      = req_i.wr && open && run_reg;
  wire  tick       = run_reg && sec_cnt_reg == '0;
  logic [31:0] rd_mux;         // Selected read value.
  // ----------------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------------
  // The key and password fields are write only and read as zero.
  always_comb begin
    rd_mux = 32'h0;
    if (sel_unlock) begin
      rd_mux = {31'h0, run_reg};
    end else if (sel_access) begin
      rd_mux = 32'(open) << ACCESS_FLAG_BIT;
    end else if (open) begin
      if (sel_freq) begin
        rd_mux = freq_reg;
      end else if (sel_time) begin
        rd_mux = time_val;
      end else if (sel_scale) begin
        rd_mux = {31'h0, scale_reg};
      end
    end
  end
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Release latch: only a reset pin brings the clock back to reset.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= 1'b0;
    end else if (key_ok) begin
      run_reg <= 1'b1;
    end
  end
  // Compensation and scale registers behind the access window.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_reg  <= FREQ_RST;
      scale_reg <= SCALE_RST;
    end else begin
      if (wr_ok && sel_freq) begin
        freq_reg <= req_i.wdata & FREQ_MASK;
      end
      if (wr_ok && sel_scale) begin
        scale_reg <= req_i.wdata[0];
      end
    end
  end
  // Read data register: valid only in the cycle after a read strobe.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= req_i.rd ? rd_mux : 32'h0;
    end
  end
  // Second prescaler; held while the clock is in reset.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_cnt_reg <= '0;
    end else if (!run_reg || sec_cnt_reg == '0) begin
      sec_cnt_reg <= ($clog2(SEC_COUNT))'(SEC_COUNT - 1);
    end else begin
      sec_cnt_reg <= sec_cnt_reg - 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  rul_window_timer #(
    .CYCLES (WINDOW_CYCLES)
  ) u_win (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .open_i     (pwd_ok),
    .open_o     (open)
  );
  rul_time_counter u_time (
    .core_clk_i              (core_clk_i),
    .rst_n_i                 (rst_n_i),
    .load_i                  (wr_ok && sel_time),
    .load_data_i             (req_i.wdata),
    .tick_i                  (tick),
    .full_day_scale_select_i (scale_reg),
    .time_o                  (time_val)
  );
  assign rdata_o   = rdata_reg;
  assign running_o = run_reg;
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_KEY_RELEASE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    key_ok |=> running_o) else $error("key did not release");
  AST_STAY_RUN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    running_o |=> running_o) else $error("clock fell back to reset");
  AST_KEY_READ_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_i.rd && sel_unlock |=> rdata_o[31:1] == 31'h0) else $error("key readable");
  AST_RUN_STATUS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_i.rd && sel_unlock |=> rdata_o[0] == running_o) else $error("status wrong");
  // The flag read back must follow the window as it stood at the strobe.
  AST_FLAG_READ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_i.rd && sel_access |=> rdata_o[16] == $past(open)) else $error("flag wrong");
  // A closed window hides the compensation value.
  AST_FREQ_HIDDEN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_i.rd && sel_freq && !open |=> rdata_o == 32'h0) else $error("freq leaked");
  // Only an accepted write to its own offset may change compensation.
  AST_FREQ_LOCKED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(wr_ok && sel_freq) |=> $stable(freq_reg)) else $error("freq written while closed");
  // The password field never reads back.
  AST_PWD_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_i.rd && sel_access |=> rdata_o[15:0] == 16'h0) else $error("password readable");
  // A wrong key, or no key, leaves the clock held.
  AST_KEY_WRONG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !running_o && !key_ok |=> !running_o) else $error("released without key");
  // While held, neither a load nor a tick may move the time digits.
  AST_HELD_TIME: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !running_o |=> $stable(time_val)) else $error("time moved while held");
  // A closed window hides the time digits as well.
  AST_TIME_HIDDEN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_i.rd && sel_time && !open |=> rdata_o == 32'h0) else $error("time leaked");
  // The scale select only moves on an accepted write to its offset.
  AST_SCALE_LOCKED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(wr_ok && sel_scale) |=> $stable(scale_reg)) else $error("scale written while closed");
  // Read data stand for one cycle only; an idle bus reads zero.
  AST_RDATA_IDLE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !req_i.rd |=> rdata_o == 32'h0) else $error("read data outstayed");
endmodule : rul_top
`default_nettype wire

//--- verilog/rul_pkg.sv
// Package for the unlock, access-window and time-of-day block.
// Assumes a single 20 MHz core clock and a plain strobe register port.
`default_nettype none
package rul_pkg;
  // ----------------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_UNLOCK     = 8'h00;   // Unlock key and run status.
  localparam logic [7:0]  OFS_ACCESS     = 8'h04;   // Access password and open flag.
  localparam logic [7:0]  OFS_FREQ       = 8'h08;   // Frequency compensation.
  localparam logic [7:0]  OFS_TIME       = 8'h0c;   // Time of day.
  localparam logic [7:0]  OFS_SCALE      = 8'h14;   // Time-scale select.
  localparam logic [30:0] UNLOCK_KEY     = 31'h52f589ab; // Key 0xa5eb1357 >> 1.
  localparam logic [15:0] ACCESS_PWD     = 16'ha965;    // Access password.
  localparam int          ACCESS_FLAG_BIT = 16;        // Open flag position.
  localparam logic [31:0] FREQ_RST       = 32'h00000700; // Compensation reset.
  localparam logic [31:0] FREQ_MASK      = 32'h00000f3f; // Integer and fraction.
  localparam logic [31:0] TIME_RST       = 32'h00000000; // Time reset.
  localparam logic [31:0] TIME_MASK      = 32'h003f7f7f; // Implemented digits.
  localparam logic        SCALE_RST      = 1'b1;         // 24-hour after reset.
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          WINDOW_CYCLES  = 1024;          // Open window length.
  localparam int          CLK_HZ         = 20000000;      // Core clock rate.
  localparam int          SEC_S          = 1;             // One tick per second.
  localparam int          SEC_CYCLES     = CLK_HZ * SEC_S; // Cycles per second.
  // Register port request bundle.
  typedef struct packed {
    logic [7:0]  addr;  // Byte address.
    logic [31:0] wdata; // Write data.
    logic        wr;    // Write strobe.
    logic        rd;    // Read strobe.
  } rul_req_t;
endpackage : rul_pkg
`default_nettype wire

//--- verilog/rul_window_timer.sv
// Access window timer: opens on a password load, closes by itself.
// Assumes the open pulse is synchronous to core_clk_i.
`default_nettype none
module rul_window_timer #(
  parameter int CYCLES = 1024  // Window length in cycles.
) (
  input  wire logic core_clk_i, // Core clock.
  input  wire logic rst_n_i,    // Async reset, active low.
  input  wire logic open_i,     // Password accepted pulse.
  output logic      open_o      // Window open level.
);
  import rul_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;       // Cycles left in the window.
  logic [CW-1:0] cnt_next;      // Next count.
  // A new password restarts the full window; otherwise count down to zero.
  assign cnt_next = open_i ? CW'(CYCLES) : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Counter register.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign open_o = (cnt_reg != '0);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Checker helper: cycles since the last password load, saturating.
  // It counts up while the window counts down, so a slip in either shows.
  logic [CW:0] age_reg;         // Cycles since the last open pulse.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age_reg <= '1;
    end else if (open_i) begin
      age_reg <= '0;
    end else if (age_reg != '1) begin
      age_reg <= age_reg + 1'b1;
    end
  end
  AST_WIN_OPEN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    open_i |=> open_o) else $error("window did not open");
  AST_WIN_SPAN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    open_o == (age_reg < (CW+1)'(CYCLES))) else $error("window length wrong");
endmodule : rul_window_timer
`default_nettype wire

//--- verilog/rul_time_counter.sv
// BCD time-of-day counter with load port and 12/24-hour rollover.
// Assumes tick_i is a one-cycle pulse once per second.
`default_nettype none
module rul_time_counter (
  input  wire logic        core_clk_i, // Core clock.
  input  wire logic        rst_n_i,    // Async reset, active low.
  input  wire logic        load_i,     // Load strobe.
  input  wire logic [31:0] load_data_i,// Load value.
  input  wire logic        tick_i,     // Second tick.
  input  wire logic        full_day_scale_select_i, // 1 = 24-hour.
  output logic [31:0]      time_o      // Current time digits.
);
  import rul_pkg::*;
  logic [31:0] time_reg;   // Digit store.
  logic [31:0] time_next;  // Next digits.
  logic [3:0] su, mu, hu;  // Units digits.
  logic [2:0] st, mt;      // Tens of seconds and minutes.
  logic [1:0] ht;          // High tens digit, bit 1 is PM in 12-hour scale.
  // ----------------------------------------------------------------------
  // Increment
  // ----------------------------------------------------------------------
  // Ripple carry through the digits; loaded values are never checked.
  always_comb begin
    su = time_reg[3:0];
    st = time_reg[6:4];
    mu = time_reg[11:8];
    mt = time_reg[14:12];
    hu = time_reg[19:16];
    ht = time_reg[21:20];
    if (su != 4'h9) begin
      su = su + 4'h1;
    end else begin
      su = 4'h0;
      if (st != 3'h5) begin
        st = st + 3'h1;
      end else begin
        st = 3'h0;
        if (mu != 4'h9) begin
          mu = mu + 4'h1;
        end else begin
          mu = 4'h0;
          if (mt != 3'h5) begin
            mt = mt + 3'h1;
          end else begin
            mt = 3'h0;
            if (full_day_scale_select_i) begin
              if (ht == 2'h2 && hu == 4'h3) begin
                ht = 2'h0;
                hu = 4'h0;
              end else if (hu == 4'h9) begin
                hu = 4'h0;
                ht = ht + 2'h1;
              end else begin
                hu = hu + 4'h1;
              end
            end else begin
              // Twelve-hour scale: 12 -> 01, 11 -> 12 flips the PM marker.
              if (ht[0] && hu == 4'h2) begin
                ht[0] = 1'b0;
                hu = 4'h1;
              end else if (ht[0] && hu == 4'h1) begin
                hu = 4'h2;
                ht[1] = ~ht[1];
              end else if (hu == 4'h9) begin
                hu = 4'h0;
                ht[0] = 1'b1;
              end else begin
                hu = hu + 4'h1;
              end
            end
          end
        end
      end
    end
    time_next = {10'h000, ht, hu, 1'b0, mt, mu, 1'b0, st, su};
  end
  // Storage: a load wins over a tick so software's value is not lost.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_reg <= TIME_RST;
    end else if (load_i) begin
      time_reg <= load_data_i & TIME_MASK;
    end else if (tick_i) begin
      time_reg <= time_next;
    end
  end
  assign time_o = time_reg;
  AST_LOAD_RAW: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    load_i |=> time_o == ($past(load_data_i) & TIME_MASK)) else $error("load altered");
endmodule : rul_time_counter
`default_nettype wire

//--- tb/test_rul_top.sv
// Self-checking bench for the unlock, access-window and time-of-day block.
// Assumes rul_pkg and rul_top are compiled first; one 20 MHz clock.
`default_nettype none
module test_rul_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rul_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and rows
  // ----------------------------------------------------------------------
  localparam int SECN = 200;     // Short second so rollover shows quickly.
  typedef struct packed {
    logic [7:0]  addr;           // Register offset.
    logic        wr;             // Write before the read.
    logic [31:0] wdata;          // Value written.
    logic [31:0] exp;            // Value the read must give.
  } rul_row_t;
  logic        core_clk_i = 1'b0; // Core clock.
  logic        rst_n_i    = 1'b0; // Reset, active low.
  rul_req_t    req_i      = '0;   // Register request.
  logic [31:0] rdata_o;           // Read data.
  logic        running_o;         // Run status.
  logic [31:0] rd_d;              // Last value read.
  int          miscompares = 0;   // Mismatches seen.
  int          checks_done = 0;   // Comparisons made.
  rul_row_t    rows [12];         // Ordinary cases.
  `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value t=%0t got %h want %h", $time, g, e); end end
  rul_top #(.SEC_COUNT(SECN)) rul_top_i (
    .core_clk_i(core_clk_i),
    .rst_n_i   (rst_n_i),
    .req_i     (req_i),
    .rdata_o   (rdata_o),
    .running_o (running_o)
  );
  // Clock at 50 ns period.
  always #25 core_clk_i = ~core_clk_i;
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  // One-cycle write strobe; the edge after drops it.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req_i.wr <= 1'b0;
    // Step off the edge so that callers see the effect of the write.
    #1;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk_i);
    req_i <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req_i.rd <= 1'b0;
    #1 rd_d = rdata_o;
  endtask : rd_reg
  // Loads a time and polls until one tick has passed, then checks the digits.
  task automatic roll(input logic [31:0] ld, input logic [31:0] nx);
    int n;
    wr_reg(OFS_ACCESS, 32'h0000a965);
    wr_reg(OFS_TIME, ld);
    n = 0;
    rd_reg(OFS_TIME);
    while (rd_d === ld && n < 400) begin
      rd_reg(OFS_TIME);
      n++;
    end
    `CHK(rd_d, nx)
  endtask : roll
  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog: the tests need well under 20000 cycles.
  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    finish_test();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rows[0]  = '{8'h08, 1'b0, 32'h0, 32'h00000700};
    rows[1]  = '{8'h0c, 1'b0, 32'h0, 32'h00000000};
    rows[2]  = '{8'h14, 1'b0, 32'h0, 32'h00000001};
    rows[3]  = '{8'h00, 1'b0, 32'h0, 32'h00000001};
    rows[4]  = '{8'h04, 1'b0, 32'h0, 32'h00010000};
    rows[5]  = '{8'h08, 1'b1, 32'hffffffff, 32'h00000f3f};
    rows[6]  = '{8'h08, 1'b1, 32'h00000a15, 32'h00000a15};
    rows[7]  = '{8'h0c, 1'b1, 32'h003f7f7f, 32'h003f7f7f};
    rows[8]  = '{8'h14, 1'b1, 32'h00000000, 32'h00000000};
    rows[9]  = '{8'h00, 1'b1, 32'h00000000, 32'h00000001};
    rows[10] = '{8'h04, 1'b1, 32'h00001234, 32'h00010000};
    rows[11] = '{8'h40, 1'b1, 32'hffffffff, 32'h00000000};
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // Locked: wrong key, and the window cannot open the registers.
    `CHK(running_o, 1'b0)
    rd_reg(OFS_UNLOCK);
    `CHK(rd_d, 32'h00000000)
    wr_reg(OFS_UNLOCK, 32'ha5eb1355);
    wr_reg(OFS_ACCESS, 32'h0000a965);
    wr_reg(OFS_FREQ, 32'h00000001);
    `CHK(running_o, 1'b0)
    wr_reg(OFS_UNLOCK, 32'ha5eb1357);
    `CHK(running_o, 1'b1)
    $display("test unlock done");
    wr_reg(OFS_ACCESS, 32'h0000a965);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr_reg(rows[i].addr, rows[i].wdata);
      end
      rd_reg(rows[i].addr);
      `CHK(rd_d, rows[i].exp)
    end
    $display("test rows done");
    // Twelve-hour scale is selected now: 11:59:59 AM turns into 12 PM.
    roll(32'h00115959, 32'h00320000);
    wr_reg(OFS_SCALE, 32'h00000001);
    roll(32'h00235959, 32'h00000000);
    roll(32'h00095959, 32'h00100000);
    $display("test rollover done");
    // The window closes by itself; then the registers hide and refuse.
    wr_reg(OFS_ACCESS, 32'h0000a965);
    // The read strobe is sampled 1024 cycles after the password: last open one.
    repeat (1022) @(posedge core_clk_i);
    rd_reg(OFS_ACCESS);
    `CHK(rd_d, 32'h00010000)
    rd_reg(OFS_ACCESS);
    `CHK(rd_d, 32'h00000000)
    rd_reg(OFS_FREQ);
    `CHK(rd_d, 32'h00000000)
    rd_reg(OFS_TIME);
    `CHK(rd_d, 32'h00000000)
    wr_reg(OFS_FREQ, 32'h00000005);
    wr_reg(OFS_SCALE, 32'h00000000);
    wr_reg(OFS_ACCESS, 32'h0000a965);
    rd_reg(OFS_FREQ);
    `CHK(rd_d, 32'h00000a15)
    rd_reg(OFS_SCALE);
    `CHK(rd_d, 32'h00000001)
    $display("test window done");
    // A reset in mid-run locks the clock again.
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    `CHK(running_o, 1'b0)
    `CHK(rdata_o, 32'h00000000)
    rst_n_i <= 1'b1;
    rd_reg(OFS_UNLOCK);
    `CHK(rd_d, 32'h00000000)
    @(posedge core_clk_i);
    #1;
    `CHK(rdata_o, 32'h00000000)
    wr_reg(OFS_UNLOCK, 32'ha5eb1357);
    `CHK(running_o, 1'b1)
    wr_reg(OFS_ACCESS, 32'h0000a965);
    rd_reg(OFS_FREQ);
    `CHK(rd_d, 32'h00000700)
    $display("test reset done");
    finish_test();
  end
endmodule : test_rul_top
`default_nettype wire
